/* rtl/pwg_consts.svh */
// Constants of the pulse width generator: offsets, fields, reset values, timing.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef PWG_CONSTS_SVH
`define PWG_CONSTS_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define PWG_SYS_CLK_KHZ 16'd20000
`define PWG_TIME_BASE_KHZ 16'd16000
`define PWG_ACC_W 16
`define PWG_TICKS_PER_STEP 2

// ****************************************************************
// Register map and fields
// ****************************************************************
`define PWG_OFS_PERIOD 32'h00000000
`define PWG_OFS_DUTY 32'h00000004
`define PWG_OFS_CONTROL 32'h00000008
`define PWG_OFS_STATUS 32'h0000000c
`define PWG_HI_BYTE_MSB 15
`define PWG_HI_BYTE_LSB 8
`define PWG_LO_FIELD_MSB 1
`define PWG_LO_FIELD_LSB 0
`define PWG_EN_BIT 0
`define PWG_RST_PERIOD 8'h3f
`define PWG_RST_PRE 2'h0
`define PWG_RST_DUTY 10'h080
`define PWG_RST_EN 1'b0
`define PWG_PRE_DIV1 2'h0
`define PWG_PRE_DIV4 2'h1
`define PWG_PRE_DIV16 2'h2
`define PWG_RESP_OKAY 2'h0
`define PWG_RESP_SLVERR 2'h2
`endif

/* rtl/pwg_pkg.sv */
// Types shared by the pulse width generator modules.
// Assumes pwg_consts.svh is on the include path.
package pwg_pkg;
  `include "pwg_consts.svh"

  typedef enum logic {PWG_OFF, PWG_RUN} pwg_phase_t;

  // State of the time base and prescaler.
  typedef struct packed {
    logic [`PWG_ACC_W-1:0] acc;
    logic [3:0] pre_cnt;
    logic tick;
  } pwg_tb_state_t;

  // Prescale factor of a prescaler code; the unused code behaves as 1:1.
  function automatic logic [4:0] pwg_pre_div(input logic [1:0] code);
    if (code == `PWG_PRE_DIV4) begin
      return 5'h04;
    end else if (code == `PWG_PRE_DIV16) begin
      return 5'h10;
    end else begin
      return 5'h01;
    end
  endfunction : pwg_pre_div
endpackage : pwg_pkg

/* rtl/pwg_tick_if.sv */
// Link between the register and pulse logic and the time base.
// Assumes both ends run on sys_clk.
`timescale 1ns/1ps
interface pwg_tick_if;
  logic run;
  logic [1:0] pre_sel;
  logic tick;
  modport ctrl (output run, output pre_sel, input tick);
  modport gen (input run, input pre_sel, output tick);
endinterface : pwg_tick_if

/* rtl/pwg_timebase.sv */
// Prescaled 16 MHz timer tick made from the 20 MHz system clock.
// Assumes the controller holds run low while the modulator is off.
`timescale 1ns/1ps
`include "pwg_consts.svh"
module pwg_timebase (
  input wire logic sys_clk,
  input wire logic reset_n,
  pwg_tick_if.gen tb
);
  import pwg_pkg::*;

  pwg_tb_state_t s;
  pwg_tb_state_t next_s;
  logic [`PWG_ACC_W-1:0] sum;

  // A fractional accumulator yields four base ticks in every five clocks.
  // The average rate is exact, but single ticks jitter by one clock.
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    sum = s.acc + `PWG_TIME_BASE_KHZ;
    if (!tb.run) begin
      next_s = '0;
    end else if (sum >= `PWG_SYS_CLK_KHZ) begin
      next_s.acc = sum - `PWG_SYS_CLK_KHZ;
      if ({1'b0, s.pre_cnt} >= pwg_pre_div(tb.pre_sel) - 5'h01) begin
        next_s.pre_cnt = 4'h0;
        next_s.tick = 1'b1;
      end else begin
        next_s.pre_cnt = s.pre_cnt + 4'h1;
      end
    end else begin
      next_s.acc = sum;
    end
  end

  // State register.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tb.tick = s.tick;
endmodule : pwg_timebase

/* rtl/pwg_top.sv */
// Pulse width generator: AXI4-Lite register slave and pulse output logic.
// Assumes a 20 MHz sys_clk and a master that keeps the AXI4-Lite handshakes.
// Assumes every input shares sys_clk, so none of them is synchronised here.
`timescale 1ns/1ps
`include "pwg_consts.svh"
module pwg_top (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic pulse_out
);
  import pwg_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************

  // All state of this module, registered as one word.
  // Keeping it in one word puts the reset value and the register in one place.
  typedef struct packed {
    logic aw_full;
    logic [31:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] period;
    logic [1:0] pre;
    logic [9:0] duty_buf;
    logic output_enable_bit;
    logic [9:0] duty_act;
    logic [8:0] fine;
    pwg_phase_t phase;
    logic pulse;
    logic [15:0] periods_done;
  } pwg_state_t;

  localparam pwg_state_t PWG_RST_STATE = '{
    aw_full: 1'b0,
    aw_addr: 32'h00000000,
    w_full: 1'b0,
    w_data: 32'h00000000,
    w_strb: 4'h0,
    bvalid: 1'b0,
    bresp: `PWG_RESP_OKAY,
    rvalid: 1'b0,
    rdata: 32'h00000000,
    rresp: `PWG_RESP_OKAY,
    period: `PWG_RST_PERIOD,
    pre: `PWG_RST_PRE,
    duty_buf: `PWG_RST_DUTY,
    output_enable_bit: `PWG_RST_EN,
    duty_act: `PWG_RST_DUTY,
    fine: 9'h000,
    phase: PWG_OFF,
    pulse: 1'b0,
    periods_done: 16'h0000
  };

  pwg_state_t s;
  pwg_state_t next_s;

  // Time base link to the prescaled tick generator.
  // The generator restarts from zero whenever the modulator is switched off,
  // so every enable begins with the same tick pattern and the same first
  // period length; a free running base would make that first period vary.
  pwg_tick_if tick_link ();

  pwg_timebase u_timebase (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .tb (tick_link.gen)
  );

  // ****************************************************************
  // Address decoding
  // ****************************************************************

  // Returns a valid flag and a register index for a byte address.
  // Only the exact aligned word is accepted; aliases would hide software bugs.
  // The status word sits beside the three setup registers and is read-only.
  function automatic logic [2:0] pwg_decode(input logic [31:0] addr);
    if (addr == `PWG_OFS_PERIOD) begin
      return 3'h4;
    end else if (addr == `PWG_OFS_DUTY) begin
      return 3'h5;
    end else if (addr == `PWG_OFS_CONTROL) begin
      return 3'h6;
    end else if (addr == `PWG_OFS_STATUS) begin
      return 3'h7;
    end else begin
      return 3'h0;
    end
  endfunction : pwg_decode

  // Merges one written byte lane into a held field.
  function automatic logic [7:0] pwg_lane(
    input logic [7:0] old_val,
    input logic [7:0] new_val,
    input logic strobe
  );
    return strobe ? new_val : old_val;
  endfunction : pwg_lane

  // Level that the output takes at the start of a period.
  // A zero duty keeps the pin low all period, so no runt pulse escapes.
  // Used both when the modulator starts and at every period end.
  function automatic logic pwg_start_level(input logic [9:0] duty);
    return duty != 10'h000;
  endfunction : pwg_start_level

  // ****************************************************************
  // Read data
  // ****************************************************************

  logic [2:0] rd_sel;
  logic [31:0] rd_word;

  // Read value of the addressed register; unimplemented bits stay zero.
  // The word is built from the address as it stands on the bus and is
  // captured at the address handshake, so the answer shows the registers
  // as they were at that edge, not when the master takes the data.
  always_comb begin
    rd_sel = pwg_decode(s_axi_araddr);
    rd_word = 32'h00000000;
    if (rd_sel == 3'h4) begin
      rd_word[`PWG_HI_BYTE_MSB:`PWG_HI_BYTE_LSB] = s.period;
      rd_word[`PWG_LO_FIELD_MSB:`PWG_LO_FIELD_LSB] = s.pre;
    end else if (rd_sel == 3'h5) begin
      rd_word[`PWG_HI_BYTE_MSB:`PWG_HI_BYTE_LSB] = s.duty_buf[9:2];
      rd_word[`PWG_LO_FIELD_MSB:`PWG_LO_FIELD_LSB] = s.duty_buf[1:0];
    end else if (rd_sel == 3'h6) begin
      rd_word[`PWG_EN_BIT] = s.output_enable_bit;
    end else if (rd_sel == 3'h7) begin
      // Status: pulse level, running flag, timer and completed periods.
      // The period count wraps; software reads it twice to measure a span.
      rd_word[0] = s.pulse;
      rd_word[1] = (s.phase == PWG_RUN);
      rd_word[15:8] = s.fine[8:1];
      rd_word[31:16] = s.periods_done;
    end else begin
      rd_word = 32'h00000000;
    end
  end

  // ****************************************************************
  // Bus handshakes
  // ****************************************************************

  // Address and data are held separately so either may arrive first.
  // No new write is taken while a response waits, which keeps one in flight.
  // The readies are plain gates on held state: they never look at a valid,
  // so no combinational path runs from the master's request back to it.
  // A write answers one cycle after its later half arrives, a read one cycle
  // after its address; a master that holds its ready low simply stalls them.
  assign s_axi_awready = !s.aw_full && !s.bvalid;
  assign s_axi_wready = !s.w_full && !s.bvalid;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign pulse_out = s.pulse;

  // The time base only runs while the modulator is active.
  // A new prescaler code acts at the next tick, as the count is compared live.
  assign tick_link.run = s.output_enable_bit;
  assign tick_link.pre_sel = s.pre;

  // ****************************************************************
  // Next state
  // ****************************************************************

  logic aw_take;
  logic w_take;
  logic have_aw;
  logic have_w;
  logic [31:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [2:0] wr_sel;
  logic [10:0] next_half;
  logic [7:0] lane_hi;
  logic [7:0] lane_lo;

  // Next state of the whole block: bus channels first, then the pulse engine.
  // Every variable of this process gets its value at the top, so no path can
  // leave one holding its last value as a latch.
  always_comb begin
    next_s = s;
    aw_take = s_axi_awvalid && s_axi_awready;
    w_take = s_axi_wvalid && s_axi_wready;
    have_aw = s.aw_full || aw_take;
    have_w = s.w_full || w_take;
    wr_addr = s.aw_full ? s.aw_addr : s_axi_awaddr;
    wr_data = s.w_full ? s.w_data : s_axi_wdata;
    wr_strb = s.w_full ? s.w_strb : s_axi_wstrb;
    wr_sel = pwg_decode(wr_addr);
    next_half = 11'h000;
    lane_hi = 8'h00;
    lane_lo = 8'h00;

    // Write channel: hold what has come, act once both halves are present.
    // A held half drops its own ready until the write completes.
    if (aw_take) begin
      next_s.aw_full = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (w_take) begin
      next_s.w_full = 1'b1;
      next_s.w_data = s_axi_wdata;
      next_s.w_strb = s_axi_wstrb;
    end
    // Both halves may land in one cycle; the write then completes at once and
    // the response rises on the next edge, with nothing held in between.
    if (have_aw && have_w) begin
      next_s.aw_full = 1'b0;
      next_s.w_full = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = wr_sel[2] ? `PWG_RESP_OKAY : `PWG_RESP_SLVERR;
      if (wr_sel == 3'h4) begin
        // Period and prescaler act at once; a count lowered below the live
        // timer lets the timer wrap through its full range before it matches.
        lane_hi = pwg_lane(s.period, wr_data[15:8], wr_strb[1]);
        lane_lo = pwg_lane({6'h00, s.pre}, wr_data[7:0], wr_strb[0]);
        next_s.period = lane_hi;
        next_s.pre = lane_lo[1:0];
      end else if (wr_sel == 3'h5) begin
        // Only the buffer changes here; the live duty waits for the period end.
        lane_hi = pwg_lane(s.duty_buf[9:2], wr_data[15:8], wr_strb[1]);
        lane_lo = pwg_lane({6'h00, s.duty_buf[1:0]}, wr_data[7:0], wr_strb[0]);
        next_s.duty_buf = {lane_hi, lane_lo[1:0]};
      end else if (wr_sel == 3'h6) begin
        // Only byte lane 0 carries the enable; the other lanes are ignored.
        if (wr_strb[0]) begin
          next_s.output_enable_bit = wr_data[`PWG_EN_BIT];
        end
      end else begin
        // Status is read-only and unmapped writes change nothing.
        next_s.period = s.period;
      end
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end

    // Read channel: answer one cycle after the address is taken.
    // The read and write channels share no state and may complete together.
    if (s_axi_arvalid && s_axi_arready) begin
      next_s.rvalid = 1'b1;
      next_s.rdata = rd_word;
      next_s.rresp = rd_sel[2] ? `PWG_RESP_OKAY : `PWG_RESP_SLVERR;
    end else if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end

    // Pulse engine. The fine counter counts prescaled ticks; the period timer
    // is fine/2, so a period spans 2 x (count+1) ticks, 512 ticks at FFh.
    case (s.phase)
      PWG_OFF: begin
        next_s.fine = 9'h000;
        next_s.pulse = 1'b0;
        if (s.output_enable_bit) begin
          // A fresh period starts at once with the buffered duty.
          next_s.phase = PWG_RUN;
          next_s.duty_act = s.duty_buf;
          next_s.pulse = pwg_start_level(s.duty_buf);
        end
      end
      // Running: the timer moves only on a prescaled tick, so apart from a disable, which
      // clears the pin at once, the output can change no more often than the tick rate allows.
      PWG_RUN: begin
        if (!s.output_enable_bit) begin
          next_s.phase = PWG_OFF;
          next_s.fine = 9'h000;
          next_s.pulse = 1'b0;
        end else if (tick_link.tick) begin
          if (s.fine == {s.period, 1'b1}) begin
            // Timer reached the period: clear it and start the next pulse.
            next_s.fine = 9'h000;
            // The buffered duty moves to the live copy only here and at start, the
            // instants when the output is being set anyway, so a write that
            // lands mid-period can neither shorten nor stretch a pulse.
            next_s.duty_act = s.duty_buf;
            next_s.pulse = pwg_start_level(s.duty_buf);
            next_s.periods_done = s.periods_done + 16'h0001;
          end else begin
            next_s.fine = s.fine + 9'h001;
            // Duty is in half ticks; the output falls at the first tick
            // boundary at or past it, so odd duties round up by half a tick.
            next_half = {1'b0, s.fine + 9'h001, 1'b0};
            if (next_half >= {1'b0, s.duty_act}) begin
              next_s.pulse = 1'b0;
            end
            // A duty beyond the period never meets the compare above.
          end
        end
      end
      // A corrupted phase returns to off; the off state then clears the pin.
      default: begin
        next_s.phase = PWG_OFF;
      end
    endcase
  end

  // ****************************************************************
  // State register
  // ****************************************************************

  // Synchronous reset loads the power-on values of every register.
  // Reset is sampled like any other input, so it must stand for at least
  // one rising edge; a shorter glitch is ignored rather than half obeyed.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s <= PWG_RST_STATE;
    end else begin
      s <= next_s;
    end
  end
endmodule : pwg_top

/* tb/pwg_asserts.sv */
// Concurrent checks on the ports of the pulse width generator top.
// Assumes a bind onto pwg_top and a master that offers address and data together.
`timescale 1ns/1ps
`include "pwg_consts.svh"
module pwg_asserts (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pulse_out
);
  import pwg_pkg::*;
  // **********
  // Helper logic
  // **********
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic en_seen;
  // Handshakes on the three request channels.
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  // Shadow of the enable bit; only joint address and data handshakes are seen.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      en_seen <= 1'b0;
    end else if (aw_hs && w_hs && s_axi_awaddr == `PWG_OFS_CONTROL && s_axi_wstrb[0]) begin
      en_seen <= s_axi_wdata[0];
    end
  end
  // **********
  // Properties
  // **********
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  sequence s_wr;
    aw_hs && w_hs;
  endsequence
  sequence s_rd_bad;
    ar_hs && s_axi_araddr[31:4] != 28'h0;
  endsequence
  sequence s_off;
    !en_seen [*5];
  endsequence
  property p_b_stand;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_stand: assert property (p_b_stand) else $error("write response left early");
  property p_r_stand;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_stand: assert property (p_r_stand) else $error("read data left early");
  property p_w_ans;
    s_wr |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready;
  endproperty
  a_w_ans: assert property (p_w_ans) else $error("write answer late");
  property p_r_ans;
    ar_hs |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_r_ans: assert property (p_r_ans) else $error("read answer late");
  property p_bad_wr;
    s_wr and s_axi_awaddr[31:4] != 28'h0 |=> s_axi_bresp == `PWG_RESP_SLVERR;
  endproperty
  a_bad_wr: assert property (p_bad_wr) else $error("unmapped write not refused");
  property p_bad_rd;
    s_rd_bad |=> s_axi_rdata == 32'h0 && s_axi_rresp == `PWG_RESP_SLVERR;
  endproperty
  a_bad_rd: assert property (p_bad_rd) else $error("unmapped read not refused");
  property p_fields;
    ar_hs && s_axi_araddr[31:3] == 29'h0 |=> s_axi_rdata[31:16] == 16'h0 && s_axi_rdata[7:2] == 6'h0;
  endproperty
  a_fields: assert property (p_fields) else $error("unused field bits set");
  property p_ctrl;
    ar_hs && s_axi_araddr == `PWG_OFS_CONTROL |=> s_axi_rdata[31:1] == 31'h0;
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control reads extra bits");
  property p_off;
    s_off |-> !pulse_out;
  endproperty
  a_off: assert property (p_off) else $error("pulse while disabled");
endmodule : pwg_asserts
bind pwg_top pwg_asserts i_pwg_asserts (.sys_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .pulse_out);

/* tb/pwg_load.sv */
// Behavioural load on the pulse output that times its edges.
// Assumes pulse_out changes only after rising edges of sys_clk.
`timescale 1ns/1ps
module pwg_load (
  input wire logic sys_clk,
  input wire logic pulse_out,
  output int rises,
  output int falls,
  output int high_len,
  output int span4
);
  // **********
  // Edge timing
  // **********
  int cyc;
  int last_rise;
  int stamps [4];
  logic prev;
  // Span over four periods is exact although single ticks jitter by a clock.
  // The pin is sampled on the falling edge, where it has settled, so the
  // counts never change in the same time step as the bench's own steps.
  initial begin
    rises = 0;
    falls = 0;
    high_len = 0;
    span4 = 0;
    cyc = 0;
    last_rise = 0;
    prev = 1'b0;
    forever begin
      @(negedge sys_clk);
      cyc++;
      if (pulse_out === 1'b1 && prev !== 1'b1) begin
        span4 = cyc - stamps[rises % 4];
        stamps[rises % 4] = cyc;
        last_rise = cyc;
        rises++;
      end
      if (pulse_out !== 1'b1 && prev === 1'b1) begin
        high_len = cyc - last_rise;
        falls++;
      end
      prev = pulse_out;
    end
  end
endmodule : pwg_load

/* tb/pulse_width_generator_bench.sv */
// Self-checking bench for the pulse width generator.
// Assumes the design, package, load model and checker are compiled first.
`timescale 1ns/1ps
`include "pwg_consts.svh"
module pulse_width_generator_bench;
  import pwg_pkg::*;
  logic sys_clk;
  logic reset_n;
  logic [31:0] s_axi_awaddr;
  logic s_axi_awvalid;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_wvalid;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready;
  logic [31:0] s_axi_araddr;
  logic s_axi_arvalid;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready;
  logic pulse_out;
  logic [31:0] rdat;
  logic [1:0] resp;
  int mismatches;
  int comparisons;
  int rises;
  int falls;
  int high_len;
  int span4;
  int miss;
  int n0;
  pwg_top i_pwg_top (.sys_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pulse_out);
  pwg_load i_pwg_load (.sys_clk, .pulse_out, .rises, .falls, .high_len, .span4);
  // The 20 MHz system clock.
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // **********
  // Shared tasks
  // **********
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Cuts a hung wait short and counts it as a mismatch.
  task automatic guard(input int n);
    if (n > 20000) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, n, 0);
      conclude();
    end
  endtask : guard
  // Ready is raised one cycle late on purpose so the response must stand.
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      guard(n);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
      end
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b1;
    @(posedge sys_clk);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [31:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      guard(n);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
      end
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge sys_clk);
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  function automatic logic [31:0] dword(input logic [9:0] d);
    return {16'h0, d[9:2], 6'h0, d[1:0]};
  endfunction : dword
  // One tick lasts 1.25 clocks, so a single high time may be off by one clock.
  function automatic logic [31:0] near(input int seen, input int ticks);
    int d;
    d = seen * 4 - ticks * 5;
    return {31'h0, d <= 4 && d >= -4};
  endfunction : near
  task automatic setup(input logic [7:0] p, input logic [1:0] pc, input logic [9:0] d);
    wr(`PWG_OFS_CONTROL, 32'h0);
    wr(`PWG_OFS_PERIOD, {16'h0, p, 6'h0, pc});
    wr(`PWG_OFS_DUTY, dword(d));
    wr(`PWG_OFS_CONTROL, 32'h1);
  endtask : setup
  task automatic wait_ev(input bit fall, input int k);
    int n;
    int goal;
    n = 0;
    goal = (fall ? falls : rises) + k;
    while ((fall ? falls : rises) < goal) begin
      @(posedge sys_clk);
      n++;
      guard(n);
    end
  endtask : wait_ev
  task automatic watch(input logic lvl);
    miss = 0;
    repeat (200) begin
      @(posedge sys_clk);
      if (pulse_out !== lvl) begin
        miss++;
      end
    end
  endtask : watch
  // **********
  // Scenarios
  // **********
  task automatic t_regs;
    rd(`PWG_OFS_PERIOD);
    chk(rdat, {16'h0, `PWG_RST_PERIOD, 6'h0, `PWG_RST_PRE});
    rd(`PWG_OFS_DUTY);
    chk(rdat, dword(`PWG_RST_DUTY));
    rd(`PWG_OFS_CONTROL);
    chk(rdat, 32'h0);
    rd(`PWG_OFS_STATUS);
    chk(rdat, 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr(32'(4 * i), 32'hffffffff);
      rd(32'(4 * i));
      chk(rdat, (i == 2) ? 32'h1 : 32'hff03);
    end
    wr(32'h10, 32'h1);
    chk(resp, `PWG_RESP_SLVERR);
    rd(32'h10);
    chk({rdat[29:0], resp}, {30'h0, `PWG_RESP_SLVERR});
    $display("test regs done");
  endtask : t_regs
  task automatic t_rate;
    logic [7:0] per [4] = '{8'h03, 8'h03, 8'h03, 8'hff};
    logic [1:0] pc [4] = '{`PWG_PRE_DIV1, `PWG_PRE_DIV4, `PWG_PRE_DIV16, `PWG_PRE_DIV1};
    int f [4] = '{1, 4, 16, 1};
    int d [4] = '{4, 4, 4, 512};
    for (int i = 0; i < 4; i++) begin
      setup(per[i], pc[i], 10'(d[i]));
      wait_ev(1'b0, 6);
      chk(span4, 5 * 2 * (per[i] + 1) * f[i]);
      wait_ev(1'b1, 1);
      chk(near(high_len, d[i] / 2 * f[i]), 32'h1);
    end
    $display("test rate done");
  endtask : t_rate
  task automatic t_edge;
    setup(8'h03, `PWG_PRE_DIV1, 10'h000);
    n0 = rises;
    watch(1'b0);
    chk(miss + rises - n0, 0);
    setup(8'h03, `PWG_PRE_DIV1, 10'h3ff);
    repeat (3) @(posedge sys_clk);
    n0 = rises;
    watch(1'b1);
    chk(miss + rises - n0, 0);
    $display("test edge done");
  endtask : t_edge
  task automatic t_buf;
    setup(8'h0f, `PWG_PRE_DIV1, 10'd40);
    wait_ev(1'b0, 2);
    wr(`PWG_OFS_DUTY, dword(10'd10));
    wait_ev(1'b1, 1);
    chk(near(high_len, 20), 32'h1);
    wait_ev(1'b1, 1);
    chk(near(high_len, 5), 32'h1);
    wr(`PWG_OFS_CONTROL, 32'h0);
    repeat (4) @(posedge sys_clk);
    watch(1'b0);
    chk(miss, 0);
    n0 = rises;
    wr(`PWG_OFS_CONTROL, 32'h1);
    repeat (5) @(posedge sys_clk);
    chk(rises - n0, 1);
    wait_ev(1'b1, 1);
    chk(near(high_len, 5), 32'h1);
    $display("test buffer done");
  endtask : t_buf
  // Reset, then the scenarios in turn.
  initial begin
    reset_n = 1'b0;
    s_axi_awaddr = 32'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 32'h0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    mismatches = 0;
    comparisons = 0;
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    t_regs();
    t_rate();
    t_edge();
    t_buf();
    conclude();
  end
endmodule : pulse_width_generator_bench
